/* File: rx_status_pkg.sv */
package rx_status_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses, word aligned)
	// ----------------------------------------------------------------
	localparam logic [31:0] SCRATCH_ADDR      = 32'h5000111c;
	localparam logic [31:0] LINE_STATUS_ADDR  = 32'h50001114;
	localparam logic [31:0] RECEIVE_BUF_ADDR  = 32'h50001100;
	localparam logic [31:0] LINE_CONTROL_ADDR = 32'h5000110c;
	localparam logic [31:0] FIFO_CONTROL_ADDR = 32'h50001108;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int          DR_BIT          = 0;
	localparam int          OE_BIT          = 1;
	localparam int          PE_BIT          = 2;
	localparam int          BI_BIT          = 4;
	localparam int          PARITY_EN_BIT   = 3;
	localparam int          FIFO_EN_BIT     = 0;
	localparam logic [7:0]  SCRATCH_RESET   = 8'h00;
	localparam logic [31:0] UNMAPPED_DATA   = 32'h00000000;
	localparam int          FIFO_DEPTH      = 16;
	localparam int          SKID_DEPTH      = 2;

	// ----------------------------------------------------------------
	// one received character from the receiver core
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] data;
		logic       parity_bad;
		logic       brk;
	} rx_char_t;

	// ----------------------------------------------------------------
	// avalon request / answer
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0] address;
		logic        read;
		logic        write;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} av_req_t;

	typedef struct packed {
		logic [31:0] readdata;
		logic        waitrequest;
	} av_rsp_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_DONE = 2'b10
	} bus_state_t;

endpackage

/* File: uart_rx_line_status_flags.sv */
`timescale 1ns/100ps
// How it works
// - a failed parity check sets the parity error flag only while the parity enable bit is set.
// - in fifo mode a parity error shows in the flag only when its character is at the fifo head.
// - a break indication also sets the parity error flag.
// - reading the line status register clears the parity error flag.
// - in non-fifo mode a character completing before the buffer is read sets overrun and overwrites.
// - in fifo mode a character completing into a full fifo sets overrun.
// - on a fifo overrun the fifo contents stay and the incoming character is dropped.
// - reading the line status register clears the overrun flag.
// - data ready is high whenever a character sits in the buffer or the fifo.
// - data ready drops on a buffer read in non-fifo mode or when the fifo empties in fifo mode.
// - an 8-bit scratch register, reset to zero, upper 24 bits read zero, no effect on operation.
// - fifo mode means the fifo enable bit is one, non-fifo mode means it is zero.
module uart_rx_line_status_flags #(
	parameter int DEPTH = rx_status_pkg::FIFO_DEPTH
) (
	// clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   rst_n,
	// avalon-mm slave
	input  wire rx_status_pkg::av_req_t av_req,
	output rx_status_pkg::av_rsp_t      av_rsp,
	// receiver core character stream
	input  wire logic                   rx_valid,
	output logic                        rx_ready,
	input  wire rx_status_pkg::rx_char_t rx_char
);
	import rx_status_pkg::*;

	localparam int AW = $clog2(DEPTH);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		bus_state_t           bus;
		logic [31:0]          rdata;
		logic [7:0]           scratch;
		logic [7:0]           line_ctrl;
		logic [7:0]           fifo_ctrl;
		logic                 pe;
		logic                 oe;
		logic                 bi;
		rx_char_t [DEPTH-1:0] fifo;
		logic [AW-1:0]        rd_ptr;
		logic [AW:0]          count;
		rx_char_t [SKID_DEPTH-1:0] skid;
		logic [1:0]           skid_cnt;
		logic                 skid_rd;
	} state_t;

	state_t state_ff;
	state_t nxt_state;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] b);
		addr_hit = (a[31:2] == b[31:2]);
	endfunction

	function automatic logic [AW-1:0] ptr_add(input logic [AW-1:0] p, input logic [AW:0] n);
		logic [AW:0] s;
		s = {1'b0, p} + n;
		if (s >= (AW+1)'(DEPTH)) begin
			s = s - (AW+1)'(DEPTH);
		end
		ptr_add = s[AW-1:0];
	endfunction

	logic     fifo_mode;
	logic     req;
	logic     status_rd;
	logic     buf_rd;
	logic     store;
	rx_char_t head;
	rx_char_t incoming;
	logic     full;
	logic     pop;

	// mode and bus decode
	always_comb begin
		fifo_mode = state_ff.fifo_ctrl[FIFO_EN_BIT];
		req       = (av_req.read | av_req.write) && state_ff.bus == BUS_IDLE;
		status_rd = req && av_req.read && addr_hit(av_req.address, LINE_STATUS_ADDR);
		buf_rd    = req && av_req.read && addr_hit(av_req.address, RECEIVE_BUF_ADDR);
		incoming  = state_ff.skid[0];
		store     = state_ff.skid_cnt != 2'd0;
		head      = state_ff.fifo[state_ff.rd_ptr];
		full      = fifo_mode ? (state_ff.count == (AW+1)'(DEPTH)) : (state_ff.count != '0);
		pop       = buf_rd && state_ff.count != '0;
	end

	// two-entry skid buffer accepts while it has room
	assign rx_ready = (state_ff.skid_cnt != 2'd2);

	// avalon answer, one wait cycle per access
	always_comb begin
		av_rsp.readdata    = state_ff.rdata;
		av_rsp.waitrequest = (state_ff.bus != BUS_DONE);
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [AW:0] cnt;
		logic        pe_set;
		logic        oe_set;
		logic        bi_set;
		logic [7:0]  receive_line_status;
		rx_char_t    nxt_head;
		logic        head_new;
		cnt       = state_ff.count;
		nxt_head  = '0;
		head_new  = 1'b0;
		pe_set    = 1'b0;
		oe_set    = 1'b0;
		bi_set    = 1'b0;
		receive_line_status       = 8'h00;
		nxt_state = state_ff;

		// skid buffer: fill from receiver core
		if (store) begin
			nxt_state.skid[0] = state_ff.skid[1];
		end
		case ({rx_valid && rx_ready, store})
			2'b10: begin
				nxt_state.skid[state_ff.skid_cnt[0]] = rx_char;
				nxt_state.skid_cnt = state_ff.skid_cnt + 2'd1;
			end
			2'b01: begin
				nxt_state.skid_cnt = state_ff.skid_cnt - 2'd1;
			end
			2'b11: begin
				nxt_state.skid[state_ff.skid_cnt[0] ^ 1'b1] = rx_char;
			end
			default: begin
			end
		endcase

		// pop head on receive buffer read
		if (pop) begin
			nxt_state.rd_ptr = ptr_add(state_ff.rd_ptr, (AW+1)'(1));
			cnt = cnt - (AW+1)'(1);
		end

		// a completed character enters buffer or fifo, or sets overrun on a full fifo
		if (store) begin
			if (!fifo_mode) begin
				oe_set = full && !pop;
				nxt_state.fifo[state_ff.rd_ptr] = incoming;
				nxt_state.rd_ptr = state_ff.rd_ptr;
				cnt = (AW+1)'(1);
				pe_set = incoming.parity_bad && state_ff.line_ctrl[PARITY_EN_BIT];
				bi_set = incoming.brk;
			end else if (full && !pop) begin
				oe_set = 1'b1;
			end else begin
				nxt_state.fifo[ptr_add(state_ff.rd_ptr, state_ff.count)] = incoming;
				cnt = cnt + (AW+1)'(1);
			end
		end

		// fifo mode: errors show once, on the edge a character becomes the head;
		// a status read of an already reported head must leave the flag cleared
		if (fifo_mode) begin
			if (pop && state_ff.count > (AW+1)'(1)) begin
				nxt_head = state_ff.fifo[ptr_add(state_ff.rd_ptr, (AW+1)'(1))];
				head_new = 1'b1;
			end else if (store && (state_ff.count == '0
				|| (pop && state_ff.count == (AW+1)'(1)))) begin
				nxt_head = incoming;
				head_new = 1'b1;
			end
		end
		if (head_new) begin
			pe_set = pe_set | (nxt_head.parity_bad && state_ff.line_ctrl[PARITY_EN_BIT]);
			bi_set = bi_set | nxt_head.brk;
		end
		nxt_state.count = cnt;

		// sticky flags, set beats the clearing read
		nxt_state.bi = (state_ff.bi && !status_rd) || bi_set;
		nxt_state.pe = (state_ff.pe && !status_rd) || pe_set || bi_set;
		nxt_state.oe = (state_ff.oe && !status_rd) || oe_set;

		// status word as read
		receive_line_status[DR_BIT] = state_ff.count != '0;
		receive_line_status[OE_BIT] = state_ff.oe;
		receive_line_status[PE_BIT] = state_ff.pe;
		receive_line_status[BI_BIT] = state_ff.bi;

		// bus slave
		case (state_ff.bus)
			BUS_IDLE: begin
				if (req) begin
					nxt_state.bus   = BUS_DONE;
					nxt_state.rdata = UNMAPPED_DATA;
					if (av_req.read) begin
						if (addr_hit(av_req.address, LINE_STATUS_ADDR)) begin
							nxt_state.rdata = {24'h000000, receive_line_status};
						end else if (addr_hit(av_req.address, RECEIVE_BUF_ADDR)) begin
							nxt_state.rdata = {24'h000000, head.data};
						end else if (addr_hit(av_req.address, SCRATCH_ADDR)) begin
							nxt_state.rdata = {24'h000000, state_ff.scratch};
						end else if (addr_hit(av_req.address, LINE_CONTROL_ADDR)) begin
							nxt_state.rdata = {24'h000000, state_ff.line_ctrl};
						end else if (addr_hit(av_req.address, FIFO_CONTROL_ADDR)) begin
							nxt_state.rdata = {24'h000000, state_ff.fifo_ctrl};
						end
					end else if (av_req.byteenable[0]) begin
						if (addr_hit(av_req.address, SCRATCH_ADDR)) begin
							nxt_state.scratch = av_req.writedata[7:0];
						end else if (addr_hit(av_req.address, LINE_CONTROL_ADDR)) begin
							nxt_state.line_ctrl = av_req.writedata[7:0];
						end else if (addr_hit(av_req.address, FIFO_CONTROL_ADDR)) begin
							nxt_state.fifo_ctrl = av_req.writedata[7:0];
							if (av_req.writedata[FIFO_EN_BIT] != state_ff.fifo_ctrl[FIFO_EN_BIT]) begin
								nxt_state.count  = '0; // mode change flushes
								nxt_state.rd_ptr = '0;
							end
						end
					end
				end
			end
			BUS_DONE: begin
				nxt_state.bus = BUS_IDLE;
			end
			default: begin
				nxt_state.bus = BUS_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_ff         <= '0;
			state_ff.bus     <= BUS_IDLE;
			state_ff.scratch <= SCRATCH_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

endmodule // uart_rx_line_status_flags

/* File: uart_rx_line_status_flags_checker.sv */
`timescale 1ns/100ps
module line_status_checker #(
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic                    clk_sys,
	input wire logic                    rst_n,
	// register bus
	input wire rx_status_pkg::av_req_t  av_req,
	input wire rx_status_pkg::av_rsp_t  av_rsp,
	// character stream
	input wire logic                    rx_valid,
	input wire logic                    rx_ready,
	input wire rx_status_pkg::rx_char_t rx_char
);
	import rx_status_pkg::*;
	logic ans;
	// a read answer is on the bus
	assign ans = av_req.read && !av_rsp.waitrequest;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	AST_ONE_WAIT: assert property ((av_req.read | av_req.write) && av_rsp.waitrequest
		&& $past(av_rsp.waitrequest) |=> !av_rsp.waitrequest) else $error("late answer");
	AST_ANSWER_ONE: assert property (!av_rsp.waitrequest |=> av_rsp.waitrequest)
		else $error("answer too long");
	AST_NO_STRAY: assert property ($fell(av_rsp.waitrequest) |-> $past(av_req.read | av_req.write))
		else $error("answer without request");
	AST_SCRATCH_HIGH: assert property (
		ans && av_req.address == SCRATCH_ADDR |-> av_rsp.readdata[31:8] == 24'h0)
		else $error("scratch upper bits set");
	AST_STATUS_HIGH: assert property (
		ans && av_req.address == LINE_STATUS_ADDR |-> av_rsp.readdata[31:8] == 24'h0)
		else $error("status upper bits set");
	AST_UNMAPPED: assert property (ans && av_req.address == 32'h50001200
		|-> av_rsp.readdata == UNMAPPED_DATA) else $error("unmapped read not zero");
	AST_READY_DROP: assert property ($fell(rx_ready) |-> $past(rx_valid))
		else $error("ready fell without traffic");
	AST_READY_RESET: assert property ($rose(rst_n) |-> rx_ready && av_rsp.waitrequest)
		else $error("bad state after reset");
endmodule // line_status_checker

bind uart_rx_line_status_flags line_status_checker #(.DEPTH(DEPTH)) line_status_checker_inst (
	.clk_sys(clk_sys), .rst_n(rst_n), .av_req(av_req), .av_rsp(av_rsp),
	.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_char(rx_char));

/* File: serial_char_source.sv */
`timescale 1ns/100ps
module serial_char_source (
	// clock
	input wire logic                clk_sys,
	// character stream
	output logic                    rx_valid,
	input wire logic                rx_ready,
	output rx_status_pkg::rx_char_t rx_char
);
	import rx_status_pkg::*;
	// idle until the first character
	initial begin
		rx_valid = 1'b0;
		rx_char  = '0;
	end
	// offer one character, hold it until taken, then scramble the idle line
	task automatic send(input logic [7:0] d, input logic pb, input logic bk);
		@(posedge clk_sys);
		rx_valid <= 1'b1;
		rx_char  <= '{data: d, parity_bad: pb, brk: bk};
		do @(posedge clk_sys); while (rx_ready !== 1'b1);
		rx_valid <= 1'b0;
		rx_char  <= ~rx_char;
	endtask
endmodule // serial_char_source

/* File: uart_rx_line_status_flags_test.sv */
`timescale 1ns/100ps
module uart_rx_line_status_flags_test;
	import rx_status_pkg::*;
	localparam logic [31:0] ST = LINE_STATUS_ADDR;
	localparam logic [31:0] RB = RECEIVE_BUF_ADDR;
	localparam logic [31:0] SM = 32'hffffff17;
	logic        clk_sys;
	logic        rst_n;
	av_req_t     req;
	av_rsp_t     rsp;
	logic        rx_valid;
	logic        rx_ready;
	rx_char_t    rx_char;
	logic [7:0]  sb;
	logic [31:0] exp_q[$];
	logic [31:0] mask_q[$];
	int          n_errors;
	int          checked;
	uart_rx_line_status_flags #(.DEPTH(4)) uart_rx_line_status_flags_inst (
		.clk_sys(clk_sys), .rst_n(rst_n), .av_req(req), .av_rsp(rsp),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_char(rx_char));
	serial_char_source serial_char_source_inst (
		.clk_sys(clk_sys), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_char(rx_char));
	// clock
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// verdict and end of run
	task automatic complete_run();
		if (n_errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// one bus access; reads leave their expectation in the queue
	task automatic bus(input logic rd, input logic [31:0] a, input logic [7:0] w,
		input logic [31:0] e, input logic [31:0] m);
		@(posedge clk_sys);
		if (rd) begin
			exp_q.push_back(e);
			mask_q.push_back(m);
		end
		req <= '{address: a, read: rd, write: !rd, byteenable: 4'hf, writedata: {24'h0, w}};
		do @(posedge clk_sys); while (rsp.waitrequest !== 1'b0);
		req.read  <= 1'b0;
		req.write <= 1'b0;
	endtask
	// send one character and let its flags settle
	task automatic tx(input logic [7:0] d, input logic pb, input logic bk);
		serial_char_source_inst.send(d, pb, bk);
		repeat (4) @(posedge clk_sys);
	endtask
	// compare each read answer with the oldest expectation
	always @(posedge clk_sys) begin
		if (req.read === 1'b1 && rsp.waitrequest === 1'b0) begin
			checked++;
			if ((rsp.readdata & mask_q[0]) !== exp_q[0]) begin
				$display("wrong value at %0t: got %h expected %h", $time,
					rsp.readdata & mask_q[0], exp_q[0]);
				n_errors++;
			end
			void'(exp_q.pop_front());
			void'(mask_q.pop_front());
		end
	end
	// watchdog
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_errors++;
		complete_run();
	end
	// main sequence
	initial begin
		n_errors = 0;
		checked  = 0;
		rst_n    = 1'b0;
		req      = '0;
		void'($urandom(32'h6d315b6d));
		sb = 8'($urandom);
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		bus(1, SCRATCH_ADDR, 0, 32'h0, '1);
		bus(0, SCRATCH_ADDR, sb, 0, 0);
		bus(1, SCRATCH_ADDR, 0, {24'h0, sb}, '1);
		bus(1, 32'h50001200, 0, 32'h0, '1);
		bus(1, ST, 0, 32'h0, SM);
		tx(sb, 0, 0);
		bus(1, ST, 0, 32'h1, SM);
		tx(~sb, 0, 0);
		bus(1, ST, 0, 32'h3, SM);
		bus(1, RB, 0, {24'h0, ~sb}, 32'hff);
		bus(1, ST, 0, 32'h0, SM);
		tx(8'h55, 1, 0);
		bus(1, RB, 0, 32'h55, 32'hff);
		bus(1, ST, 0, 32'h0, SM);
		bus(0, LINE_CONTROL_ADDR, 8'h08, 0, 0);
		tx(8'h5a, 1, 0);
		bus(1, ST, 0, 32'h5, SM);
		bus(1, ST, 0, 32'h1, SM);
		bus(1, RB, 0, 32'h5a, 32'hff);
		tx(8'h00, 0, 1);
		bus(1, RB, 0, 32'h0, 32'hff);
		bus(1, ST, 0, 32'h14, SM);
		bus(0, FIFO_CONTROL_ADDR, 8'h01, 0, 0);
		tx(8'h11, 0, 0);
		tx(8'h22, 1, 0);
		bus(1, ST, 0, 32'h1, SM);
		bus(1, RB, 0, 32'h11, 32'hff);
		bus(1, ST, 0, 32'h5, SM);
		bus(1, RB, 0, 32'h22, 32'hff);
		bus(1, ST, 0, 32'h0, SM);
		for (int i = 0; i <= 4; i++)
			tx(sb + 8'(i), 0, 0);
		bus(1, ST, 0, 32'h3, SM);
		for (int i = 0; i < 4; i++)
			bus(1, RB, 0, {24'h0, sb + 8'(i)}, 32'hff);
		bus(1, ST, 0, 32'h0, SM);
		complete_run();
	end
endmodule // uart_rx_line_status_flags_test
